// ### rtl/alu_rsx_regs.svh
// register offsets, field positions, reset values and widths of the alu block
// assumes: included by its bare name from rtl/, after the package is compiled
`ifndef ALU_RSX_REGS_SVH
`define ALU_RSX_REGS_SVH

// register offsets on the plain software port
`define ALU_OFF_STATUS   2'h0
`define ALU_OFF_ACC      2'h1
`define ALU_OFF_WDT      2'h2
`define ALU_OFF_CTRL     2'h3

// status register bit positions
`define ALU_ST_CARRY     0
`define ALU_ST_DIGIT     1
`define ALU_ST_ZERO      2
`define ALU_ST_PWRDN     3
`define ALU_ST_TO        4
`define ALU_ST_SLEEP     5

// control register bit positions
`define ALU_CTRL_WDT_EN  0
`define ALU_CTRL_WAKE    1

// reset values
`define ALU_RST_ACC      8'h00
`define ALU_RST_WDT_EN   1'b1
`define ALU_RST_TO       1'b1
`define ALU_RST_PWRDN    1'b1

// watchdog widths and terminal values
`define WDT_PRE_W        8
`define WDT_CNT_W        8
`define WDT_PRE_MAX      8'hFF
`define WDT_CNT_MAX      8'hFF

`endif

// ### rtl/alu_rsx_pkg.sv
// types and decode helpers shared by the alu block and its watchdog
// assumes: compiled before every other file of the block
package alu_rsx_pkg;

  // instruction selector driven by the decoder
  typedef enum logic [2:0] {
    OP_ROTATE_RIGHT = 3'h0, // rotate_right_carry_op
    OP_SUB_REG      = 3'h1, // sub_acc_from_reg_op
    OP_SUB_LIT      = 3'h2, // sub_acc_from_literal_op
    OP_SWAP         = 3'h3, // nibble_swap_op
    OP_XOR_LIT      = 3'h4, // xor_literal_op
    OP_XOR_REG      = 3'h5, // xor_register_op
    OP_SLEEP        = 3'h6,
    OP_NOP          = 3'h7
  } op_t;

  // power state of the core, one-hot
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } pwr_state_t;

  // instruction carries a target_select operand
  function automatic logic has_target(input op_t op);
    return (op == OP_ROTATE_RIGHT) || (op == OP_SUB_REG) ||
           (op == OP_SWAP) || (op == OP_XOR_REG);
  endfunction

  // instruction updates the result_null_flag
  function automatic logic sets_zero(input op_t op);
    return (op == OP_SUB_REG) || (op == OP_SUB_LIT) ||
           (op == OP_XOR_LIT) || (op == OP_XOR_REG);
  endfunction

  // instruction takes the literal rather than the file register
  function automatic logic uses_literal(input op_t op);
    return (op == OP_SUB_LIT) || (op == OP_XOR_LIT);
  endfunction

endpackage

// ### rtl/wdt_if.sv
// carrier between the alu core and its watchdog unit
// assumes: both ends run on i_clk_sys
`timescale 1ns/100ps
`default_nettype none

interface wdt_if;
  logic       enable;   // count while high
  logic       clear;    // zero counter and prescaler at next edge
  logic       overflow; // one-cycle pulse on counter wrap
  logic [7:0] count;
  logic [7:0] prescale;

  modport ctrl (output enable, output clear, input overflow, input count, input prescale);
  modport unit (input enable, input clear, output overflow, output count, output prescale);
endinterface

`default_nettype wire

// ### rtl/wdt_unit.sv
// watchdog counter with its prescaler
// assumes: enable and clear come from the alu core in the same clock domain
`timescale 1ns/100ps
`default_nettype none

`include "alu_rsx_regs.svh"

module wdt_unit
  import alu_rsx_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  wdt_if.unit       wdt
);

  logic [`WDT_PRE_W-1:0] prescale;
  logic [`WDT_PRE_W-1:0] next_prescale;
  logic [`WDT_CNT_W-1:0] count;
  logic [`WDT_CNT_W-1:0] next_count;
  logic                  overflow;
  logic                  next_overflow;

  // -------------------------------------------------------------
  // next values: clear beats counting
  // -------------------------------------------------------------
  always_comb begin
    next_prescale = prescale;
    next_count    = count;
    next_overflow = 1'b0;
    if (wdt.clear) begin
      next_prescale = '0;
      next_count    = '0;
    end else if (wdt.enable) begin
      next_prescale = prescale + 8'h01;
      if (prescale == `WDT_PRE_MAX) begin
        next_count    = count + 8'h01;
        next_overflow = (count == `WDT_CNT_MAX);
      end
    end
  end

  // registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      prescale <= '0;
      count    <= '0;
      overflow <= 1'b0;
    end else begin
      prescale <= next_prescale;
      count    <= next_count;
      overflow <= next_overflow;
    end
  end

  assign wdt.prescale = prescale;
  assign wdt.count    = count;
  assign wdt.overflow = overflow;

endmodule // wdt_unit

`default_nettype wire

// ### rtl/alu_rotate_subtract_xor_ops.sv
// execution datapath: rotate, subtract, swap, xor and the sleep side effects
// assumes: decoder issues one-cycle i_exec pulses with operands stable beside
// them; the register file takes o_reg_wr_* as a one-cycle write
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

`include "alu_rsx_regs.svh"

// What this block does
// - target_select 0 to accumulator, 1 to register
// - rotate right through borrow_not_flag only
// - register minus accumulator, to chosen target
// - subtracts update carry, digit, zero flags only
// - literal minus accumulator into accumulator, flags
// - sleep clears watchdog counter and prescaler
// - sleep sets timeout_flag, clears power_down_flag
// - sleep halts oscillator, enters sleep state
// - swap nibbles, no flag changes
// - xor literal into accumulator, zero flag only
// - xor register to chosen target, zero only
module alu_rotate_subtract_xor_ops
  import alu_rsx_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // decoder side
  input  wire logic       i_exec,
  input  wire op_t        i_op,
  input  wire logic       i_target_select,
  input  wire logic [7:0] i_literal,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic [7:0] i_reg_operand,
  // register file side
  output logic            o_reg_wr_en,
  output logic      [6:0] o_reg_wr_addr,
  output logic      [7:0] o_reg_wr_data,
  output logic      [7:0] o_acc,
  output logic      [7:0] o_result,
  output logic            o_borrow_not_flag,
  output logic            o_digit_borrow_flag,
  output logic            o_result_null_flag,
  output logic            o_timeout_flag,
  output logic            o_power_down_flag,
  output logic            o_osc_run,
  // software port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  pwr_state_t pwr;
  pwr_state_t next_pwr;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic [7:0] result;
  logic [7:0] next_result;
  logic       carry;
  logic       next_carry;
  logic       digit;
  logic       next_digit;
  logic       zero;
  logic       next_zero;
  logic       timeout;
  logic       next_timeout;
  logic       power_down;
  logic       next_power_down;
  logic       osc_run;
  logic       next_osc_run;
  logic       wr_en;
  logic       next_wr_en;
  logic [6:0] wr_addr;
  logic [6:0] next_wr_addr;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;
  logic       wdt_en;
  logic       next_wdt_en;
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  // datapath intermediates
  logic       take;
  logic       sleep_take;
  logic [7:0] operand_b;
  logic [8:0] diff;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_digit;

  wdt_if wdt ();

  wdt_unit u_wdt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .wdt       (wdt.unit)
  );

  // instructions are only taken while the core runs
  assign take       = i_exec && (pwr == ST_RUN);
  assign sleep_take = take && (i_op == OP_SLEEP);

  // watchdog control
  assign wdt.enable = wdt_en;
  assign wdt.clear  = sleep_take;

  // -------------------------------------------------------------
  // arithmetic and logic unit
  // -------------------------------------------------------------
  always_comb begin
    operand_b = uses_literal(i_op) ? i_literal : i_reg_operand;
    diff      = {1'b0, operand_b} - {1'b0, acc};
    alu_res   = acc;
    alu_c     = carry;
    alu_digit = digit;
    case (i_op)
      OP_ROTATE_RIGHT: begin
        alu_res = {carry, i_reg_operand[7:1]};
        alu_c   = i_reg_operand[0];
      end
      OP_SUB_REG, OP_SUB_LIT: begin
        alu_res = diff[7:0];
        alu_c   = ~diff[8];
        alu_digit = (acc[3:0] <= operand_b[3:0]);
      end
      OP_SWAP: begin
        alu_res = {i_reg_operand[3:0], i_reg_operand[7:4]};
      end
      OP_XOR_LIT, OP_XOR_REG: begin
        alu_res = acc ^ operand_b;
      end
      default: begin
        alu_res = acc;
      end
    endcase
  end

  // -------------------------------------------------------------
  // next values of core state
  // -------------------------------------------------------------
  always_comb begin
    next_pwr        = pwr;
    next_acc        = acc;
    next_result     = result;
    next_carry      = carry;
    next_digit      = digit;
    next_zero       = zero;
    next_timeout    = timeout;
    next_power_down = power_down;
    next_wr_en      = 1'b0;
    next_wr_addr    = wr_addr;
    next_wr_data    = wr_data;
    next_wdt_en     = wdt_en;
    // software writes to the accumulator lose to an instruction that writes the accumulator
    if (i_wr && (i_addr == `ALU_OFF_ACC)) begin
      next_acc = i_wdata;
    end
    if (i_wr && (i_addr == `ALU_OFF_CTRL)) begin
      next_wdt_en = i_wdata[`ALU_CTRL_WDT_EN];
      if (i_wdata[`ALU_CTRL_WAKE] && (pwr == ST_SLEEP)) begin
        next_pwr = ST_RUN;
      end
    end
    // watchdog wrap marks a timeout and wakes the core unless a sleep is taken in the same cycle
    if (wdt.overflow) begin
      next_timeout = 1'b0;
      next_pwr     = ST_RUN;
    end
    case (pwr)
      ST_RUN: begin
        if (sleep_take) begin
          next_timeout    = 1'b1;
          next_power_down = 1'b0;
          next_pwr        = ST_SLEEP;
        end else if (take && (i_op != OP_NOP)) begin
          next_result = alu_res;
          next_carry  = alu_c;
          next_digit  = alu_digit;
          if (sets_zero(i_op)) begin
            next_zero = (alu_res == 8'h00);
          end
          if (has_target(i_op) && i_target_select) begin
            next_wr_en   = 1'b1;
            next_wr_addr = i_reg_addr;
            next_wr_data = alu_res;
          end else begin
            next_acc = alu_res;
          end
        end
      end
      ST_SLEEP: begin
        next_pwr = next_pwr;
      end
      default: begin
        next_pwr = ST_RUN;
      end
    endcase
    next_osc_run = (next_pwr == ST_RUN);
  end

  // -------------------------------------------------------------
  // read data, valid only in the cycle after a read strobe
  // -------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ALU_OFF_STATUS: begin
          next_rdata[`ALU_ST_CARRY] = carry;
          next_rdata[`ALU_ST_DIGIT] = digit;
          next_rdata[`ALU_ST_ZERO]  = zero;
          next_rdata[`ALU_ST_PWRDN] = power_down;
          next_rdata[`ALU_ST_TO]    = timeout;
          next_rdata[`ALU_ST_SLEEP] = (pwr == ST_SLEEP);
        end
        `ALU_OFF_ACC:  next_rdata = acc;
        `ALU_OFF_WDT:  next_rdata = wdt.count;
        `ALU_OFF_CTRL: next_rdata[`ALU_CTRL_WDT_EN] = wdt_en;
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pwr        <= ST_RUN;
      acc        <= `ALU_RST_ACC;
      result     <= 8'h00;
      carry      <= 1'b0;
      digit      <= 1'b0;
      zero       <= 1'b0;
      timeout    <= `ALU_RST_TO;
      power_down <= `ALU_RST_PWRDN;
      osc_run    <= 1'b1;
      wr_en      <= 1'b0;
      wr_addr    <= 7'h00;
      wr_data    <= 8'h00;
      wdt_en     <= `ALU_RST_WDT_EN;
      rdata      <= 8'h00;
    end else begin
      pwr        <= next_pwr;
      acc        <= next_acc;
      result     <= next_result;
      carry      <= next_carry;
      digit      <= next_digit;
      zero       <= next_zero;
      timeout    <= next_timeout;
      power_down <= next_power_down;
      osc_run    <= next_osc_run;
      wr_en      <= next_wr_en;
      wr_addr    <= next_wr_addr;
      wr_data    <= next_wr_data;
      wdt_en     <= next_wdt_en;
      rdata      <= next_rdata;
    end
  end

  // outputs straight from flops
  assign o_reg_wr_en         = wr_en;
  assign o_reg_wr_addr       = wr_addr;
  assign o_reg_wr_data       = wr_data;
  assign o_acc               = acc;
  assign o_result            = result;
  assign o_borrow_not_flag   = carry;
  assign o_digit_borrow_flag = digit;
  assign o_result_null_flag  = zero;
  assign o_timeout_flag      = timeout;
  assign o_power_down_flag   = power_down;
  assign o_osc_run           = osc_run;
  assign o_rdata             = rdata;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence issue_s(op_t op);
    take && (i_op == op);
  endsequence

  sequence target_op_s;
    take && has_target(i_op);
  endsequence

  dest_acc_a: assert property (
    target_op_s ##0 !i_target_select |=> !o_reg_wr_en && (acc == result))
    else $error("target 0 did not land in accumulator");

  dest_reg_a: assert property (
    target_op_s ##0 i_target_select |=> o_reg_wr_en && $stable(acc)
      && (o_reg_wr_addr == $past(i_reg_addr)) && (o_reg_wr_data == result))
    else $error("target 1 did not write the file register");

  rotate_a: assert property (
    issue_s(OP_ROTATE_RIGHT) |=> (result == {$past(carry), $past(i_reg_operand[7:1])})
      && (carry == $past(i_reg_operand[0])) && $stable(digit) && $stable(zero))
    else $error("rotate right result or flags wrong");

  sub_reg_a: assert property (
    issue_s(OP_SUB_REG) |=> result == ($past(i_reg_operand) - $past(acc)))
    else $error("register minus accumulator wrong");

  sub_flags_a: assert property (
    (issue_s(OP_SUB_REG) or issue_s(OP_SUB_LIT)) ##0 !wdt.overflow
      |=> (carry == ($past(acc) <= $past(operand_b)))
      && (digit == ($past(acc[3:0]) <= $past(operand_b[3:0])))
      && $stable(timeout) && $stable(power_down))
    else $error("subtract flags wrong");

  sub_lit_a: assert property (
    issue_s(OP_SUB_LIT) |=> (acc == ($past(i_literal) - $past(acc))) && !o_reg_wr_en)
    else $error("literal minus accumulator wrong");

  wdt_clear_a: assert property (
    issue_s(OP_SLEEP) |=> (wdt.count == 8'h00) && (wdt.prescale == 8'h00))
    else $error("sleep left watchdog uncleared");

  sleep_flags_a: assert property (
    issue_s(OP_SLEEP) |=> timeout && !power_down && $stable(carry)
      && $stable(digit) && $stable(zero))
    else $error("sleep status bits wrong");

  sleep_halt_a: assert property (
    issue_s(OP_SLEEP) ##1 !(i_wr && (i_addr == `ALU_OFF_CTRL)) |-> !o_osc_run [*2])
    else $error("oscillator still running after sleep");

  swap_a: assert property (
    issue_s(OP_SWAP) |=> (result == {$past(i_reg_operand[3:0]), $past(i_reg_operand[7:4])})
      && $stable(carry) && $stable(digit) && $stable(zero))
    else $error("nibble swap wrong or flags touched");

  xor_lit_a: assert property (
    issue_s(OP_XOR_LIT) |=> (acc == ($past(acc) ^ $past(i_literal)))
      && $stable(carry) && $stable(digit))
    else $error("xor literal wrong");

  xor_reg_a: assert property (
    issue_s(OP_XOR_REG) |=> (result == ($past(acc) ^ $past(i_reg_operand)))
      && $stable(carry) && $stable(digit))
    else $error("xor register wrong");

  zero_flag_a: assert property (
    take && sets_zero(i_op) |=> zero == (result == 8'h00))
    else $error("zero flag disagrees with result");

endmodule // alu_rotate_subtract_xor_ops

`default_nettype wire

// ### dv/reg_file_model.sv
// register file model that stands beside the alu datapath
// assumes: one clock; reads are combinational, writes land at the rising edge
`timescale 1ns/100ps
`default_nettype none

module reg_file_model (
  input  wire logic       i_clk_sys,
  input  wire logic [6:0] i_rd_addr,
  output logic      [7:0] o_rd_data,
  input  wire logic       i_wr_en,
  input  wire logic [6:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data
);
  logic [7:0] mem [128];

  // operand follows the address at once, as the decoder presents it
  assign o_rd_data = mem[i_rd_addr];

  // write-back port, one byte per pulse
  always @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end
endmodule // reg_file_model

`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the rotate, subtract, swap, xor and sleep datapath
// assumes: rtl package and header on the include path, model in dv/
`timescale 1ns/100ps
`default_nettype none

`include "alu_rsx_regs.svh"

module tb_top
  import alu_rsx_pkg::*;
();
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  logic       exec_en = 1'b0;
  op_t        op      = OP_NOP;
  logic       tsel    = 1'b0;
  logic [7:0] lit     = 8'h00;
  logic [6:0] raddr   = 7'h00;
  logic [1:0] addr    = 2'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] operand, wr_data, acc, result, rdata;
  logic [6:0] wr_addr;
  logic       reg_wr_en, c_flag, digit_flag, z_flag, to_flag, pwrdn_flag, osc_run;
  logic [7:0] m_acc = 8'h00;
  logic       m_c = 1'b0, m_digit = 1'b0, m_z = 1'b0, m_to = 1'b1, m_pwrdn = 1'b1;
  int         n_errors = 0;
  int         comparisons = 0;

  // free-running system clock, 10 ns period
  always #5 clk_sys = ~clk_sys;

  alu_rotate_subtract_xor_ops i_dut (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_exec(exec_en), .i_op(op),
    .i_target_select(tsel), .i_literal(lit), .i_reg_addr(raddr),
    .i_reg_operand(operand), .o_reg_wr_en(reg_wr_en), .o_reg_wr_addr(wr_addr),
    .o_reg_wr_data(wr_data), .o_acc(acc), .o_result(result),
    .o_borrow_not_flag(c_flag), .o_digit_borrow_flag(digit_flag),
    .o_result_null_flag(z_flag), .o_timeout_flag(to_flag),
    .o_power_down_flag(pwrdn_flag), .o_osc_run(osc_run), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));

  reg_file_model i_rf (
    .i_clk_sys(clk_sys), .i_rd_addr(raddr), .o_rd_data(operand),
    .i_wr_en(reg_wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data));

  // ------------------------------
  // compare, report and bus tasks
  // ------------------------------
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk8(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  task automatic sw_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask

  task automatic set_acc(input logic [7:0] v);
    sw_write(`ALU_OFF_ACC, v);
    m_acc = v;
    @(negedge clk_sys);
    chk8("acc_write", v, acc);
  endtask

  task automatic check_state();
    chk8("acc", m_acc, acc);
    chk1("borrow_not", m_c, c_flag);
    chk1("digit_borrow", m_digit, digit_flag);
    chk1("result_null", m_z, z_flag);
    chk1("timeout", m_to, to_flag);
    chk1("power_down", m_pwrdn, pwrdn_flag);
  endtask

  // one issue pulse, outputs sampled mid-cycle after the taking edge
  task automatic issue(input op_t o, input logic t, input logic [7:0] k, input logic [6:0] a);
    @(posedge clk_sys);
    op      <= o;
    tsel    <= t;
    lit     <= k;
    raddr   <= a;
    exec_en <= 1'b1;
    @(posedge clk_sys);
    exec_en <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic run_op(input op_t o, input logic t, input logic [7:0] k, input logic [6:0] a);
    logic [7:0] f;
    logic [7:0] r;
    logic       dst;
    issue(o, t, k, a);
    f   = i_rf.mem[a];
    dst = t && (o == OP_ROTATE_RIGHT || o == OP_SUB_REG || o == OP_SWAP || o == OP_XOR_REG);
    case (o)
      OP_ROTATE_RIGHT: begin
        r   = {m_c, f[7:1]};
        m_c = f[0];
      end
      OP_SUB_REG: begin
        r    = f - m_acc;
        m_c  = (m_acc <= f);
        m_digit = (m_acc[3:0] <= f[3:0]);
      end
      OP_SUB_LIT: begin
        r    = k - m_acc;
        m_c  = (m_acc <= k);
        m_digit = (m_acc[3:0] <= k[3:0]);
      end
      OP_SWAP:    r = {f[3:0], f[7:4]};
      OP_XOR_LIT: r = m_acc ^ k;
      default:    r = m_acc ^ f;
    endcase
    if (o != OP_ROTATE_RIGHT && o != OP_SWAP) begin
      m_z = (r == 8'h00);
    end
    if (!dst) begin
      m_acc = r;
    end
    chk1("reg_wr_en", dst, reg_wr_en);
    if (dst) begin
      chk8("reg_wr_addr", {1'b0, a}, {1'b0, wr_addr});
      chk8("reg_wr_data", r, wr_data);
    end
    chk8("result", r, result);
    check_state();
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    logic [7:0] d;
    check_state();
    chk1("osc_run", 1'b1, osc_run);
    sw_read(`ALU_OFF_STATUS, d);
    chk8("status", 8'h18, d);
  endtask

  // equal, smaller, larger and nibble-only borrow, both targets, top address
  task automatic t_sub_reg();
    logic [7:0] fv [4] = '{8'h05, 8'h03, 8'h10, 8'h42};
    logic [7:0] av [4] = '{8'h03, 8'h05, 8'h01, 8'h42};
    for (int i = 0; i < 4; i++) begin
      i_rf.mem[7'(124 + i)] = fv[i];
      set_acc(av[i]);
      run_op(OP_SUB_REG, ~i[0], 8'h00, 7'(124 + i));
    end
  endtask

  // literal boundaries; target_select high must not cause a write-back
  task automatic t_sub_lit();
    set_acc(8'h00);
    run_op(OP_SUB_LIT, 1'b1, 8'hFF, 7'h01);
    run_op(OP_SUB_LIT, 1'b1, 8'h00, 7'h01);
  endtask

  // a zero swap result leaves the null flag alone
  task automatic t_swap();
    i_rf.mem[7'h20] = 8'hA5;
    i_rf.mem[7'h21] = 8'h00;
    run_op(OP_SWAP, 1'b1, 8'h00, 7'h20);
    run_op(OP_SWAP, 1'b0, 8'h00, 7'h20);
    run_op(OP_SWAP, 1'b0, 8'h00, 7'h21);
  endtask

  // chained rotates read back their own write-back
  task automatic t_rotate();
    i_rf.mem[7'h10] = 8'hE6;
    i_rf.mem[7'h11] = 8'h01;
    run_op(OP_ROTATE_RIGHT, 1'b1, 8'h00, 7'h10);
    run_op(OP_ROTATE_RIGHT, 1'b1, 8'h00, 7'h10);
    run_op(OP_ROTATE_RIGHT, 1'b0, 8'h00, 7'h11);
  endtask

  task automatic t_xor();
    i_rf.mem[7'h30] = 8'h3C;
    run_op(OP_XOR_LIT, 1'b0, m_acc, 7'h00);
    run_op(OP_XOR_LIT, 1'b0, 8'h81, 7'h00);
    run_op(OP_XOR_REG, 1'b1, 8'h00, 7'h30);
    run_op(OP_XOR_REG, 1'b0, 8'h00, 7'h30);
  endtask

  task automatic t_sleep();
    logic [7:0] d;
    int         n;
    // let the watchdog run out so the timeout flag drops first
    for (n = 0; n < 70000 && to_flag !== 1'b0; n++) @(negedge clk_sys);
    m_to = 1'b0;
    // let the prescaler run far enough that an uncleared watchdog would tick
    repeat (200) @(negedge clk_sys);
    check_state();
    issue(OP_SLEEP, 1'b0, 8'h00, 7'h00);
    m_to = 1'b1;
    m_pwrdn = 1'b0;
    chk1("osc_run", 1'b0, osc_run);
    check_state();
    repeat (240) @(posedge clk_sys);
    sw_read(`ALU_OFF_WDT, d);
    chk8("wdt_count", 8'h00, d);
    sw_read(`ALU_OFF_STATUS, d);
    chk8("status", {3'b001, m_to, m_pwrdn, m_z, m_digit, m_c}, d);
    // an issue while asleep is dropped
    issue(OP_XOR_LIT, 1'b0, 8'hFF, 7'h00);
    check_state();
    sw_write(`ALU_OFF_CTRL, 8'h03);
    for (n = 0; n < 4 && osc_run !== 1'b1; n++) @(negedge clk_sys);
    chk1("osc_run_wake", 1'b1, osc_run);
    run_op(OP_XOR_LIT, 1'b0, 8'h0F, 7'h00);
    // accumulator read back over the software port, then idle read data
    sw_read(`ALU_OFF_ACC, d);
    chk8("acc_read", m_acc, d);
    @(negedge clk_sys);
    chk8("rdata_idle", 8'h00, rdata);
  endtask

  // reset, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_sub_reg();
    t_sub_lit();
    t_swap();
    t_rotate();
    t_xor();
    t_sleep();
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
